// ### hw/gpo_pkg.sv
// Constants, field layouts and helpers for the guarded output port control.
// Assumes a 100 MHz clock and a 32-bit classic Wishbone register bus.
package gpo_pkg;
	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned CLK_NS       = 10;
	localparam int unsigned TICK_NS      = 1_000_000;
	localparam int unsigned TICK_CYCLES  = TICK_NS / CLK_NS;
	localparam int unsigned NV_WR_NS     = 100_000;
	localparam int unsigned NV_WR_CYCLES = NV_WR_NS / CLK_NS;
	localparam int unsigned MWD_TICKS    = 8;
	localparam int unsigned NCH          = 7;

	// Register byte offsets
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_REPLY  = 8'h04;
	localparam logic [7:0] OFS_RDATA0 = 8'h08;
	localparam logic [7:0] OFS_RDATA1 = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CFG    = 8'h14;
	localparam logic [7:0] OFS_VALUES = 8'h18;
	localparam logic [7:0] OFS_HWD    = 8'h1c;
	localparam logic [7:0] OFS_NVCFG  = 8'h20;

	// Command opcodes in bits 3:0 of the command word
	localparam logic [3:0] OP_PORT_WR  = 4'h1;
	localparam logic [3:0] OP_CHAN_WR  = 4'h2;
	localparam logic [3:0] OP_MOD_STAT = 4'h3;
	localparam logic [3:0] OP_CLR_TO   = 4'h4;
	localparam logic [3:0] OP_RST_STAT = 4'h5;
	localparam logic [3:0] OP_IO_STAT  = 4'h6;
	localparam logic [3:0] OP_CFG_SET  = 4'h7;
	localparam logic [3:0] OP_PROTO    = 4'h8;

	// Field positions
	localparam int unsigned ARG0_LSB    = 8;
	localparam int unsigned ARG1_LSB    = 16;
	localparam int unsigned ARG2_LSB    = 24;
	localparam int unsigned VAL_SAFE_LSB = 8;
	localparam int unsigned ST_TO_BIT   = 8;
	localparam int unsigned ST_RST_BIT  = 9;
	localparam int unsigned ST_REC_BIT  = 10;
	localparam int unsigned ST_BUSY_BIT = 11;
	localparam int unsigned FMT_EDGE_BIT = 7;
	localparam int unsigned FMT_CSUM_BIT = 6;
	localparam logic [7:0]  FMT_RSVD_MASK = 8'h3f;

	// Reply characters
	localparam logic [7:0] CH_OK    = 8'h3e;
	localparam logic [7:0] CH_EXCL  = 8'h21;
	localparam logic [7:0] CH_BAD   = 8'h3f;
	localparam logic [7:0] ASC_ZERO = 8'h30;
	localparam logic [7:0] ASC_ALPHA = 8'h37;

	// Channel write selectors and values
	localparam logic [7:0] BB_MULTI0 = 8'h00;
	localparam logic [7:0] BB_MULTI1 = 8'h0a;
	localparam logic [3:0] BB_ONE0   = 4'h1;
	localparam logic [3:0] BB_ONE1   = 4'ha;
	localparam logic [7:0] DD_CLR    = 8'h00;
	localparam logic [7:0] DD_SET    = 8'h01;

	// Module status codes
	localparam logic [7:0] MOD_STAT_TO = 8'h04;
	localparam logic [7:0] MOD_STAT_OK = 8'h00;

	// Configuration values
	localparam logic [7:0] FACT_ADDR = 8'h01;
	localparam logic [7:0] FACT_BAUD = 8'h06;
	localparam logic [7:0] FACT_FMT  = 8'h00;
	localparam logic [7:0] REC_ADDR  = 8'h00;
	localparam logic [7:0] REC_BAUD  = 8'h06;
	localparam logic [7:0] REC_FMT   = 8'h00;
	localparam logic       PROTO_ASCII = 1'b0;
	localparam logic       PROTO_RTU   = 1'b1;
	localparam logic [15:0] HWD_RST  = 16'h0000;
	localparam logic [7:0] BAUD_MIN  = 8'h03;
	localparam logic [7:0] BAUD_MAX  = 8'h0a;
	localparam logic [16:0] BAUD_DIV [8] = '{
		17'(CLK_HZ / 1200), 17'(CLK_HZ / 2400), 17'(CLK_HZ / 4800),
		17'(CLK_HZ / 9600), 17'(CLK_HZ / 19200), 17'(CLK_HZ / 38400),
		17'(CLK_HZ / 57600), 17'(CLK_HZ / 115200)};

	// Clock cycles per bit for a baud code; an unknown code falls back to 9600
	function automatic logic [16:0] baud_div(input logic [7:0] code);
		logic [7:0] idx;
		idx = (code < BAUD_MIN || code > BAUD_MAX) ? REC_BAUD - BAUD_MIN : code - BAUD_MIN;
		return BAUD_DIV[idx[2:0]];
	endfunction

	function automatic logic [7:0] hex_ascii(input logic [3:0] n);
		return (n < 4'ha) ? ASC_ZERO + {4'h0, n} : ASC_ALPHA + {4'h0, n};
	endfunction

	// Two characters, the high nibble's character in the low byte (sent first)
	function automatic logic [15:0] hex_pair(input logic [7:0] b);
		return {hex_ascii(b[3:0]), hex_ascii(b[7:4])};
	endfunction
endpackage

// ### hw/guarded_output_port_control.sv
// Seven-channel output port control with host watchdog, reset flag and recovery strap.
// Assumes a Wishbone master on clk_i; the strap pin is asynchronous to it.
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
module guarded_output_port_control #(
	parameter int unsigned NCH          = gpo_pkg::NCH,
	parameter int unsigned TICK_CYCLES  = gpo_pkg::TICK_CYCLES,
	parameter int unsigned NV_WR_CYCLES = gpo_pkg::NV_WR_CYCLES,
	parameter int unsigned MWD_TICKS    = gpo_pkg::MWD_TICKS,
	parameter bit          RTU_VARIANT  = 1'b0
)(
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	input  wire logic           wb_cyc_i,
	input  wire logic           wb_stb_i,
	input  wire logic           wb_we_i,
	input  wire logic [7:0]     wb_adr_i,
	input  wire logic [3:0]     wb_sel_i,
	input  wire logic [31:0]    wb_dat_i,
	output logic      [31:0]    wb_dat_o,
	output logic                wb_ack_o,
	input  wire logic           strap_n_i,
	input  wire logic           nv_factory_i,
	output logic      [NCH-1:0] dout_o,
	output logic      [7:0]     link_addr_o,
	output logic      [16:0]    baud_div_o,
	output logic                csum_en_o,
	output logic                count_rise_o,
	output logic                proto_rtu_o,
	output logic                recov_o,
	output logic                timeout_o
);
	localparam int unsigned NVW = $clog2(NV_WR_CYCLES + 1);
	localparam int unsigned TW  = $clog2(TICK_CYCLES + 1);

	typedef enum logic [1:0] {S_BOOT, S_IDLE, S_NVWR} state_t;

	// Cells that survive every reset
	typedef struct packed {
		logic [7:0]     addr;
		logic [7:0]     baud;
		logic [7:0]     fmt;
		logic           proto;
		logic           to;
		logic [NCH-1:0] pov;
		logic [NCH-1:0] safe;
		logic [15:0]    hwd;
	} nv_t;

	typedef struct packed {
		state_t         state;
		logic           strap_s1;
		logic           strap_s2;
		logic           recov;
		logic [NCH-1:0] outs;
		logic           rst_flag;
		logic           ack;
		logic [31:0]    dat;
		logic [7:0]     delim;
		logic [3:0]     rlen;
		logic [31:0]    rdat0;
		logic [15:0]    rdat1;
		logic [7:0]     act_addr;
		logic [7:0]     act_baud;
		logic [7:0]     act_fmt;
		logic           act_proto;
		logic [16:0]    baud_div;
		logic [NVW-1:0] nv_cnt;
		logic [7:0]     stg_addr;
		logic [7:0]     stg_baud;
		logic [7:0]     stg_fmt;
		logic           stg_proto;
		nv_t            nv;
	} st_t;

	st_t            st_r;
	st_t            st_nxt;
	nv_t            keep_nv;
	logic           req;
	logic           cmd_wr;
	logic           wr_ack;
	logic           exec;
	logic           busy;
	logic           rst_any;
	logic           mwd_rst;
	logic           tick;
	logic           hwd_exp;
	logic           hwd_restart;
	logic           refresh;
	logic           chg;
	logic [31:0]    rd_mux;
	logic [3:0]     op;
	logic [7:0]     arg0;
	logic [7:0]     arg1;
	logic [7:0]     arg2;
	logic [NCH-1:0] ch_mask;

	assign req     = wb_cyc_i & wb_stb_i;
	assign cmd_wr  = req & wb_we_i & (wb_adr_i == gpo_pkg::OFS_CMD);
	assign busy    = st_r.state != S_IDLE;
	assign wr_ack  = req & wb_we_i & st_r.ack;
	assign exec    = wr_ack & (wb_adr_i == gpo_pkg::OFS_CMD) & wb_sel_i[0] & ~busy;
	assign rst_any = rst_i | mwd_rst;
	assign op      = wb_dat_i[3:0];
	assign arg0    = wb_dat_i[gpo_pkg::ARG0_LSB +: 8];
	assign arg1    = wb_dat_i[gpo_pkg::ARG1_LSB +: 8];
	assign arg2    = wb_dat_i[gpo_pkg::ARG2_LSB +: 8];
	assign ch_mask = NCH'(1) << arg0[3:0];

	// Handling counts as alive while it sits idle or a save is still running
	assign refresh = (st_r.state == S_IDLE) || (st_r.state == S_BOOT) ||
		(st_r.state == S_NVWR && st_r.nv_cnt < NVW'(NV_WR_CYCLES));

	// Millisecond tick, host watchdog and module watchdog share one counter design
	tick_timer #(.W(TW)) u_tick (
		.clk_i     (clk_i),
		.rst_i     (rst_any),
		.tick_i    (1'b1),
		.restart_i (1'b0),
		.en_i      (1'b1),
		.limit_i   (TW'(TICK_CYCLES)),
		.expire_o  (tick)
	);

	tick_timer #(.W(16)) u_host_wd (
		.clk_i     (clk_i),
		.rst_i     (rst_any),
		.tick_i    (tick),
		.restart_i (hwd_restart),
		.en_i      (~st_r.nv.to),
		.limit_i   (st_r.nv.hwd),
		.expire_o  (hwd_exp)
	);

	// Its own reset is rst_i only, so a bite cannot hold itself in reset
	tick_timer #(.W(16)) u_module_wd (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.tick_i    (tick),
		.restart_i (refresh),
		.en_i      (1'b1),
		.limit_i   (16'(MWD_TICKS)),
		.expire_o  (mwd_rst)
	);

	// Read data for the current address; unmapped addresses read zero
	always_comb
	begin
		rd_mux = '0;
		case (wb_adr_i)
			gpo_pkg::OFS_REPLY:  rd_mux = {20'h0, st_r.rlen, st_r.delim};
			gpo_pkg::OFS_RDATA0: rd_mux = st_r.rdat0;
			gpo_pkg::OFS_RDATA1: rd_mux = {16'h0, st_r.rdat1};
			gpo_pkg::OFS_STATUS:
			begin
				rd_mux[NCH-1:0]              = st_r.outs;
				rd_mux[gpo_pkg::ST_TO_BIT]   = st_r.nv.to;
				rd_mux[gpo_pkg::ST_RST_BIT]  = st_r.rst_flag;
				rd_mux[gpo_pkg::ST_REC_BIT]  = st_r.recov;
				rd_mux[gpo_pkg::ST_BUSY_BIT] = busy;
			end
			gpo_pkg::OFS_CFG:
				rd_mux = {7'h0, st_r.act_proto, st_r.act_fmt, st_r.act_baud, st_r.act_addr};
			gpo_pkg::OFS_VALUES:
			begin
				rd_mux[NCH-1:0]                          = st_r.nv.pov;
				rd_mux[gpo_pkg::VAL_SAFE_LSB +: NCH]     = st_r.nv.safe;
			end
			gpo_pkg::OFS_HWD:    rd_mux = {16'h0, st_r.nv.hwd};
			gpo_pkg::OFS_NVCFG:
				rd_mux = {7'h0, st_r.nv.proto, st_r.nv.fmt, st_r.nv.baud, st_r.nv.addr};
			default:             rd_mux = '0;
		endcase
	end

	// Next state: bus, command execution, watchdog events, then resets
	always_comb
	begin
		st_nxt          = st_r;
		hwd_restart     = 1'b0;
		keep_nv         = st_r.nv;
		chg             = (arg1 != st_r.nv.baud) ||
			(arg2[gpo_pkg::FMT_CSUM_BIT] != st_r.nv.fmt[gpo_pkg::FMT_CSUM_BIT]);
		st_nxt.strap_s1 = strap_n_i;
		st_nxt.strap_s2 = st_r.strap_s1;
		// A command write waits for ack while a save or boot is running
		st_nxt.ack      = req & ~st_r.ack & ~(busy & cmd_wr);
		if (req & ~st_r.ack)
			st_nxt.dat = rd_mux;
		case (st_r.state)
			S_BOOT:
			begin
				st_nxt.recov = ~st_r.strap_s2;
				if (~st_r.strap_s2)
				begin
					st_nxt.act_addr  = gpo_pkg::REC_ADDR;
					st_nxt.act_baud  = gpo_pkg::REC_BAUD;
					st_nxt.act_fmt   = gpo_pkg::REC_FMT;
					st_nxt.act_proto = gpo_pkg::PROTO_ASCII;
				end
				else
				begin
					st_nxt.act_addr  = st_r.nv.addr;
					st_nxt.act_baud  = st_r.nv.baud;
					st_nxt.act_fmt   = st_r.nv.fmt;
					st_nxt.act_proto = st_r.nv.proto;
				end
				st_nxt.baud_div = gpo_pkg::baud_div(~st_r.strap_s2 ?
					gpo_pkg::REC_BAUD : st_r.nv.baud);
				st_nxt.state    = S_IDLE;
			end
			S_NVWR:
			begin
				// Saved values reach the cells only; active settings wait for boot
				if (st_r.nv_cnt >= NVW'(NV_WR_CYCLES - 1))
				begin
					st_nxt.nv.addr  = st_r.stg_addr;
					st_nxt.nv.baud  = st_r.stg_baud;
					st_nxt.nv.fmt   = st_r.stg_fmt;
					st_nxt.nv.proto = st_r.stg_proto;
					st_nxt.state    = S_IDLE;
				end
				else
					st_nxt.nv_cnt = st_r.nv_cnt + NVW'(1);
			end
			S_IDLE:
			begin
				if (exec)
				begin
					hwd_restart  = 1'b1;
					st_nxt.delim = gpo_pkg::CH_EXCL;
					st_nxt.rlen  = 4'h0;
					st_nxt.rdat0 = '0;
					st_nxt.rdat1 = '0;
					case (op)
						gpo_pkg::OP_PORT_WR:
						begin
							if (st_r.nv.to)
								st_nxt.delim = gpo_pkg::CH_EXCL;
							else if ((arg0 >> NCH) != 8'h00)
								st_nxt.delim = gpo_pkg::CH_BAD;
							else
							begin
								st_nxt.outs  = arg0[NCH-1:0];
								st_nxt.delim = gpo_pkg::CH_OK;
							end
						end
						gpo_pkg::OP_CHAN_WR:
						begin
							st_nxt.delim = gpo_pkg::CH_BAD;
							if (st_r.nv.to)
								st_nxt.delim = gpo_pkg::CH_EXCL;
							else if ((arg0 == gpo_pkg::BB_MULTI0 ||
								arg0 == gpo_pkg::BB_MULTI1) && (arg1 >> NCH) == 8'h00)
							begin
								st_nxt.outs  = arg1[NCH-1:0];
								st_nxt.delim = gpo_pkg::CH_OK;
							end
							else if ((arg0[7:4] == gpo_pkg::BB_ONE0 ||
								arg0[7:4] == gpo_pkg::BB_ONE1) && arg0[3:0] < 4'(NCH))
							begin
								if (arg1 == gpo_pkg::DD_CLR)
								begin
									st_nxt.outs  = st_r.outs & ~ch_mask;
									st_nxt.delim = gpo_pkg::CH_OK;
								end
								else if (arg1 == gpo_pkg::DD_SET)
								begin
									st_nxt.outs  = st_r.outs | ch_mask;
									st_nxt.delim = gpo_pkg::CH_OK;
								end
							end
						end
						gpo_pkg::OP_MOD_STAT:
						begin
							st_nxt.rdat0 = {16'h0, gpo_pkg::hex_pair(st_r.nv.to ?
								gpo_pkg::MOD_STAT_TO : gpo_pkg::MOD_STAT_OK)};
							st_nxt.rlen  = 4'h2;
						end
						gpo_pkg::OP_CLR_TO:
							st_nxt.nv.to = 1'b0;
						gpo_pkg::OP_RST_STAT:
						begin
							st_nxt.rdat0    = {8'h00, gpo_pkg::ASC_ZERO + {7'h0, st_r.rst_flag},
								gpo_pkg::hex_pair(st_r.act_addr)};
							st_nxt.rlen     = 4'h3;
							st_nxt.rst_flag = 1'b0;
						end
						gpo_pkg::OP_IO_STAT:
						begin
							// First byte channels, second byte zero, then the status tail
							st_nxt.rdat0 = {gpo_pkg::hex_pair(8'h00),
								gpo_pkg::hex_pair(8'(st_r.outs))};
							st_nxt.rdat1 = gpo_pkg::hex_pair(8'h00);
							st_nxt.rlen  = 4'h6;
						end
						gpo_pkg::OP_CFG_SET:
						begin
							if ((chg && !st_r.recov) || arg1 < gpo_pkg::BAUD_MIN ||
								arg1 > gpo_pkg::BAUD_MAX ||
								(arg2 & gpo_pkg::FMT_RSVD_MASK) != 8'h00)
								st_nxt.delim = gpo_pkg::CH_BAD;
							else
							begin
								st_nxt.stg_addr  = arg0;
								st_nxt.stg_baud  = arg1;
								st_nxt.stg_fmt   = arg2;
								st_nxt.stg_proto = st_r.nv.proto;
								st_nxt.nv_cnt    = '0;
								st_nxt.state     = S_NVWR;
								st_nxt.rdat0     = {16'h0, gpo_pkg::hex_pair(arg0)};
								st_nxt.rlen      = 4'h2;
							end
						end
						gpo_pkg::OP_PROTO:
						begin
							if (!st_r.recov)
								st_nxt.delim = gpo_pkg::CH_BAD;
							else
							begin
								st_nxt.stg_addr  = st_r.nv.addr;
								st_nxt.stg_baud  = st_r.nv.baud;
								st_nxt.stg_fmt   = st_r.nv.fmt;
								st_nxt.stg_proto = arg0[0];
								st_nxt.nv_cnt    = '0;
								st_nxt.state     = S_NVWR;
							end
						end
						default: st_nxt.delim = gpo_pkg::CH_BAD;
					endcase
				end
			end
			default: st_nxt.state = S_BOOT;
		endcase
		// Predefined values and host watchdog interval, by byte lane
		if (wr_ack && wb_adr_i == gpo_pkg::OFS_VALUES)
		begin
			if (wb_sel_i[0])
				st_nxt.nv.pov = wb_dat_i[NCH-1:0];
			if (wb_sel_i[1])
				st_nxt.nv.safe = wb_dat_i[gpo_pkg::VAL_SAFE_LSB +: NCH];
		end
		if (wr_ack && wb_adr_i == gpo_pkg::OFS_HWD)
		begin
			if (wb_sel_i[0])
				st_nxt.nv.hwd[7:0] = wb_dat_i[7:0];
			if (wb_sel_i[1])
				st_nxt.nv.hwd[15:8] = wb_dat_i[15:8];
		end
		// Expiry wins over a clear-timeout command in the same cycle
		if (hwd_exp)
		begin
			st_nxt.nv.to = 1'b1;
			st_nxt.outs  = st_r.nv.safe;
		end
		if (nv_factory_i)
		begin
			st_nxt.nv.addr  = gpo_pkg::FACT_ADDR;
			st_nxt.nv.baud  = gpo_pkg::FACT_BAUD;
			st_nxt.nv.fmt   = gpo_pkg::FACT_FMT;
			st_nxt.nv.proto = RTU_VARIANT ? gpo_pkg::PROTO_RTU : gpo_pkg::PROTO_ASCII;
			st_nxt.nv.to    = 1'b0;
			st_nxt.nv.pov   = '0;
			st_nxt.nv.safe  = '0;
			st_nxt.nv.hwd   = gpo_pkg::HWD_RST;
		end
		// Any reset keeps the cells and the synchroniser, sets the reset flag, loads the outputs from the cells and clears the rest
		if (rst_any)
		begin
			keep_nv         = st_nxt.nv;
			st_nxt          = '0;
			st_nxt.nv       = keep_nv;
			st_nxt.strap_s1 = strap_n_i;
			st_nxt.strap_s2 = st_r.strap_s1;
			st_nxt.state    = S_BOOT;
			st_nxt.rst_flag = 1'b1;
			st_nxt.outs     = keep_nv.to ? keep_nv.safe : keep_nv.pov;
		end
	end

	always_ff @(posedge clk_i)
		st_r <= st_nxt;

	assign wb_dat_o     = st_r.dat;
	assign wb_ack_o     = st_r.ack;
	assign dout_o       = st_r.outs;
	assign link_addr_o  = st_r.act_addr;
	assign baud_div_o   = st_r.baud_div;
	assign csum_en_o    = st_r.act_fmt[gpo_pkg::FMT_CSUM_BIT];
	assign count_rise_o = st_r.act_fmt[gpo_pkg::FMT_EDGE_BIT];
	assign proto_rtu_o  = st_r.act_proto;
	assign recov_o      = st_r.recov;
	assign timeout_o    = st_r.nv.to;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_bite;
		mwd_rst ##1 st_r.state == S_BOOT;
	endsequence

	a_recov_boot: assert property (
		st_r.state == S_BOOT && !st_r.strap_s2 && !rst_any |=>
		link_addr_o == gpo_pkg::REC_ADDR && !csum_en_o && st_r.act_baud == gpo_pkg::REC_BAUD)
		else $error("recovery boot did not load recovery settings");
	a_cfg_guard: assert property (
		exec && op == gpo_pkg::OP_CFG_SET && chg && !st_r.recov && !rst_any |=>
		st_r.delim == gpo_pkg::CH_BAD && st_r.state == S_IDLE)
		else $error("baud or checksum change accepted outside recovery");
	a_pov_reset: assert property (
		st_r.state == S_BOOT && !st_r.nv.to |-> dout_o == st_r.nv.pov)
		else $error("outputs not at power-on value after reset");
	a_timeout_safe: assert property (
		hwd_exp && !rst_any && !nv_factory_i |=> timeout_o && dout_o == $past(st_r.nv.safe))
		else $error("host watchdog expiry did not force safe value");
	a_write_ignored: assert property (
		exec && st_r.nv.to && (op == gpo_pkg::OP_PORT_WR || op == gpo_pkg::OP_CHAN_WR) &&
		!rst_any |=> st_r.delim == gpo_pkg::CH_EXCL && $stable(dout_o))
		else $error("output write applied while timed out");
	a_flag_sticky: assert property (
		timeout_o && !(exec && op == gpo_pkg::OP_CLR_TO) && !nv_factory_i |=> timeout_o)
		else $error("timeout flag cleared without clear command");
	a_write_ok: assert property (
		exec && op == gpo_pkg::OP_PORT_WR && !st_r.nv.to && !hwd_exp && !rst_any &&
		arg0[7] == 1'b0 |=> dout_o == $past(arg0[NCH-1:0]) && st_r.delim == gpo_pkg::CH_OK)
		else $error("port write not applied");
	a_rst_flag: assert property (
		exec && op == gpo_pkg::OP_RST_STAT && !rst_any |=>
		!st_r.rst_flag ##1 (!st_r.rst_flag || $past(mwd_rst)))
		else $error("reset flag not cleared by reset-status read");
	a_cfg_defer: assert property (
		st_r.state == S_NVWR && !rst_any |=> $stable(link_addr_o) && $stable(baud_div_o))
		else $error("saved configuration took effect before reset");
	a_bite_reset: assert property (
		s_bite |=> st_r.state == S_IDLE && st_r.rst_flag)
		else $error("module watchdog bite did not restart the block");
endmodule

// ### hw/tick_timer.sv
// Interval counter: counts enable ticks and pulses once when the limit is reached.
// Assumes ticks and controls come from logic on the same clock.
`timescale 1ns/10ps
module tick_timer #(
	parameter int unsigned W = 16
)(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         tick_i,
	input  wire logic         restart_i,
	input  wire logic         en_i,
	input  wire logic [W-1:0] limit_i,
	output logic              expire_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         exp;
	} tmr_t;

	tmr_t st_r;
	tmr_t st_nxt;

	// Restart or disable clears the count; the limit wraps it with a pulse
	always_comb
	begin
		st_nxt     = st_r;
		st_nxt.exp = 1'b0;
		if (!en_i || restart_i || limit_i == '0)
			st_nxt.cnt = '0;
		else if (tick_i)
		begin
			if (st_r.cnt >= limit_i - W'(1))
			begin
				st_nxt.cnt = '0;
				st_nxt.exp = 1'b1;
			end
			else
				st_nxt.cnt = st_r.cnt + W'(1);
		end
		if (rst_i)
			st_nxt = '0;
	end

	always_ff @(posedge clk_i)
		st_r <= st_nxt;

	assign expire_o = st_r.exp;
endmodule

// ### verification/test_guarded_output_port_control.sv
// Self-checking bench: command and register traffic through the host model.
// Assumes short interval parameters so timeouts and saves finish quickly.
`timescale 1ns/10ps
module test_guarded_output_port_control;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        strap_n = 1'b1;
	logic        nv_fact = 1'b1;
	logic        cyc, stb, we, ack, tout, csum;
	logic        rec, rise, prtu;
	logic [3:0]  sel;
	logic [7:0]  adr, laddr;
	logic [31:0] wdat, rdat, v;
	logic [6:0]  dout;
	logic [16:0] bdiv;
	int          num_errors = 0;
	int          n_compared = 0;
	int          cycles = 0;

	always #5 clk_i = ~clk_i;

	guarded_output_port_control #(
		.TICK_CYCLES (20),
		.NV_WR_CYCLES(8)
	) u_guarded_output_port_control (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.strap_n_i(strap_n), .nv_factory_i(nv_fact), .dout_o(dout), .link_addr_o(laddr),
		.baud_div_o(bdiv), .csum_en_o(csum), .count_rise_o(rise), .proto_rtu_o(prtu),
		.recov_o(rec), .timeout_o(tout));

	wb_host u_wb_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));

	task automatic wrap_up;
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Command word, then its reply word
	task automatic cmd(input logic [31:0] w, input logic [31:0] rep);
		u_wb_host.xfer(1'b1, 8'h00, w, v);
		u_wb_host.xfer(1'b0, 8'h04, '0, v);
		chk("reply", rep, v);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		u_wb_host.xfer(1'b0, a, '0, v);
		chk("register", e, v);
	endtask

	// Reset held n edges; factory load only rides the first one
	task automatic boot(input int n);
		rst_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		rst_i <= 1'b0;
		nv_fact <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	// Hang guard: far above the few hundred cycles the sequence needs
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			wrap_up;
		end
	end

	initial
	begin
		boot(16);
		rdc(8'h14, 32'h0000_0601);
		cmd(32'h5, 32'h321);
		rdc(8'h08, 32'h0031_3130);
		cmd(32'h5, 32'h321);
		rdc(8'h08, 32'h0030_3130);
		cmd(32'h5501, 32'h3e);
		cmd(32'h0000_1002, 32'h3e);
		cmd(32'h0001_1102, 32'h3e);
		chk("outputs", 32'h56, dout);
		cmd(32'h6, 32'h621);
		rdc(8'h08, 32'h3030_3635);
		rdc(8'h0c, 32'h0000_3030);
		cmd(32'h0007_0107, 32'h3f);
		cmd(32'h0000_0108, 32'h3f);
		// Safe 2a, power-on 11, two-tick host interval
		u_wb_host.xfer(1'b1, 8'h18, 32'h2a11, v);
		u_wb_host.xfer(1'b1, 8'h1c, 32'h2, v);
		repeat (200)
			if (tout !== 1'b1)
				@(posedge clk_i);
		chk("outputs", 32'h2a, dout);
		cmd(32'h3, 32'h221);
		rdc(8'h08, 32'h3430);
		cmd(32'h7f01, 32'h21);
		chk("outputs", 32'h2a, dout);
		boot(3);
		chk("timeout", 32'h1, tout);
		chk("outputs", 32'h2a, dout);
		cmd(32'h4, 32'h21);
		u_wb_host.xfer(1'b1, 8'h1c, 32'h0, v);
		boot(3);
		chk("outputs", 32'h11, dout);
		strap_n <= 1'b0;
		boot(4);
		rdc(8'h14, 32'h0000_0600);
		chk("recovery", 32'h1, rec);
		// Protocol save first; the config write then stalls until it is stored
		cmd(32'h0000_0108, 32'h21);
		cmd(32'hc007_0207, 32'h221);
		repeat (10) @(posedge clk_i);
		rdc(8'h20, 32'h01c0_0702);
		chk("address", 32'h0, laddr);
		strap_n <= 1'b1;
		boot(4);
		chk("recovery", 32'h0, rec);
		chk("divider", 32'h0000_1458, bdiv);
		chk("address", 32'h2, laddr);
		chk("checksum", 32'h1, csum);
		chk("count edge", 32'h1, rise);
		chk("protocol", 32'h1, prtu);
		wrap_up;
	end
endmodule

// ### verification/wb_host.sv
// Host side model: a classic Wishbone master making one access at a time.
// Assumes the slave answers on clk_i; a lost ack is left to the bench timer.
`timescale 1ns/10ps
module wb_host (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [3:0]       sel_o,
	output logic [7:0]       adr_o,
	output logic [31:0]      dat_o
);
	initial
	begin
		{cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} = '0;
	end

	// Request held until the edge that samples ack, then released; no local limit,
	// so a stalled command write simply waits and a lost ack ends in the bench timer
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <= {2'b11, w, 4'hf, a, wd};
		@(posedge clk_i);
		while (ack_i !== 1'b1)
			@(posedge clk_i);
		rd = dat_i;
		{cyc_o, stb_o, we_o} <= 3'b000;
	endtask
endmodule
